/* File: verilog/tbi_pkg.sv */
// Shared constants, state type and functions for the tape byte interface.
`default_nettype none
package tbi_pkg;
  // Clock and divider chain.
  localparam int unsigned CLK_HZ    = 100_000_000;
  localparam int unsigned TOG_IN_HZ = 3_000_000;
  localparam int unsigned SQ_HZ     = 1_500_000;
  localparam int unsigned SQ_DIV    = 5;
  localparam int unsigned TICK_HZ   = 300_000;
  localparam int unsigned CHAR_HZ   = 10_000;
  localparam int unsigned PRE_CYC   = CLK_HZ / TOG_IN_HZ;
  localparam int unsigned RATE_DIV  = TICK_HZ / CHAR_HZ;
  localparam int unsigned PULSE_NS  = 3000;
  localparam int unsigned PULSE_CYC = (PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
  // Read block end detection.
  localparam int unsigned READ_GAP_US  = 200;
  localparam int unsigned STOP_DLY_US  = 1000;
  localparam int unsigned READ_GAP_CYC = READ_GAP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned STOP_DLY_CYC = STOP_DLY_US * (CLK_HZ / 1_000_000);
  // Character format and end-of-block sequence.
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned CMD_W     = 6;
  localparam logic [2:0]  GAP_CHARS = 3'h4;
  localparam logic [7:0]  CRC_POLY  = 8'h3C;
  localparam logic [7:0]  CRC_FINAL = 8'hD7;
  localparam logic [7:0]  FILE_MARK = 8'h13;
  localparam logic [7:0]  RESET_BYTE = 8'h00;
  // Command and status bit positions.
  localparam int unsigned CMD_FWD   = 0;
  localparam int unsigned CMD_WSTAT = 1;
  localparam int unsigned STAT_RDY  = 0;
  localparam int unsigned STAT_PERR = 1;
  localparam int unsigned STAT_DRV  = 2;

  typedef enum logic [1:0] {
    WS_IDLE    = 2'b00,
    WS_CRC_GAP = 2'b01,
    WS_LRC_GAP = 2'b11,
    WS_AMP     = 2'b10
  } tbi_wseq_t;

  // Parity bit that makes a nine-bit character odd.
  function automatic logic tbi_odd_par(input logic [7:0] b);
    tbi_odd_par = ~^b;
  endfunction : tbi_odd_par

  // One cyclic check update for a written byte.
  function automatic logic [7:0] tbi_crc_step(input logic [7:0] crc,
                                              input logic [7:0] data);
    logic [7:0] x;
    logic [7:0] r;
    x = crc ^ data;
    r = {tbi_odd_par(x), x[7:1]};
    tbi_crc_step = x[0] ? (r ^ CRC_POLY) : r;
  endfunction : tbi_crc_step
endpackage : tbi_pkg
`default_nettype wire

/* File: verilog/tbi_rate_gen.sv */
// Write timing chain: toggle, divide by five, rate divider, 3 us pulse.
`timescale 1ns/10ps
`default_nettype none
module tbi_rate_gen #(
  parameter int unsigned PRE_CYC   = tbi_pkg::PRE_CYC,
  parameter int unsigned PULSE_CYC = tbi_pkg::PULSE_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       run,
  input  wire logic [7:0] rate_div,
  // Base write pulse
  output logic            base_q,
  output logic            base_start
);
  localparam logic [7:0] PRE_LAST = 8'(PRE_CYC - 1);
  localparam logic [8:0] WID_LAST = 9'(PULSE_CYC - 1);
  localparam logic [2:0] SQ_LAST  = 3'(tbi_pkg::SQ_DIV - 1);

  logic [7:0] pre_q, pre_d, rate_q, rate_d;
  logic [8:0] wid_q, wid_d;
  logic [2:0] five_q, five_d;
  logic       sq_q, sq_d, base_d, tick;

  always_comb begin
    pre_d = pre_q;
    sq_d = sq_q;
    five_d = five_q;
    rate_d = rate_q;
    wid_d = wid_q;
    base_d = base_q;
    tick = 1'b0;
    base_start = 1'b0;
    if (!run) begin
      pre_d = '0;
      sq_d = 1'b0;
      five_d = '0;
      rate_d = '0;
      wid_d = '0;
      base_d = 1'b0;
    end else begin
      if (pre_q == PRE_LAST) begin
        pre_d = '0;
        sq_d = ~sq_q;
        if (!sq_q) begin
          if (five_q == SQ_LAST) begin
            five_d = '0;
            tick = 1'b1;
          end else begin
            five_d = five_q + 3'h1;
          end
        end
      end else begin
        pre_d = pre_q + 8'h01;
      end
      if (tick && rate_div != 8'h00) begin
        if (rate_q >= rate_div - 8'h01) begin
          rate_d = '0;
          base_start = 1'b1;
        end else begin
          rate_d = rate_q + 8'h01;
        end
      end
      if (base_start) begin
        base_d = 1'b1;
        wid_d = '0;
      end else if (base_q) begin
        if (wid_q == WID_LAST) begin
          base_d = 1'b0;
        end else begin
          wid_d = wid_q + 9'h001;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_q <= '0;
      sq_q <= 1'b0;
      five_q <= '0;
      rate_q <= '0;
      wid_q <= '0;
      base_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      sq_q <= sq_d;
      five_q <= five_d;
      rate_q <= rate_d;
      wid_q <= wid_d;
      base_q <= base_d;
    end
  end

  a_pulse_width: assert property (@(posedge clk) disable iff (rst || !run)
    $rose(base_q) |-> ##299 base_q ##1 !base_q)
    else $error("Base write pulse is not 3 us wide.");
  a_stop_idle: assert property (@(posedge clk) disable iff (rst)
    !run |=> !base_q)
    else $error("Base pulse while the timer is stopped.");
endmodule : tbi_rate_gen
`default_nettype wire

/* File: verilog/tbi_tape_if.sv */
// Processor-side interface logic for a nine-track tape drive.
`timescale 1ns/10ps
`default_nettype none
module tbi_tape_if #(
  parameter int unsigned GAP_CYC  = tbi_pkg::READ_GAP_CYC,
  parameter int unsigned STOP_CYC = tbi_pkg::STOP_DLY_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Configuration
  input  wire logic       cfg_done,
  input  wire logic       timer_run,
  input  wire logic [7:0] rate_div,
  // Command control
  input  wire logic [5:0] cmd_port,
  input  wire logic       write_mode,
  input  wire logic       rd_active,
  // Write byte stream from the processor
  input  wire logic [7:0] wr_in,
  input  wire logic       wr_in_valid,
  output logic            wr_in_ready,
  // Write gates and block ending
  input  wire logic       wr_strobe_gate,
  input  wire logic       amp_clear_gate,
  input  wire logic       crc_clear,
  input  wire logic       end_block,
  input  wire logic       file_mark_req,
  output logic            seq_busy,
  output logic [7:0]      cyclic_check_char,
  // Read side to the processor
  output logic [7:0]      rd_byte,
  input  wire logic       rd_ack,
  output logic [7:0]      status_byte,
  output logic            rd_ready_flag_out,
  output logic            rd_block_end,
  // Drive read pins
  input  wire logic [7:0] rd_byte_lines,
  input  wire logic       rd_parity_line,
  input  wire logic       rd_char_strobe,
  input  wire logic [5:0] drive_status_bits,
  output logic            rd_char_clock,
  // Drive write and command pins
  output logic [7:0]      wr_byte_lines,
  output logic            wr_parity_line,
  output logic            wr_char_strobe,
  output logic            wr_amp_clear_pulse,
  output logic [5:0]      drive_cmd_bits
);
  localparam int unsigned GW = $clog2(GAP_CYC + 1);
  localparam int unsigned SW = $clog2(STOP_CYC + 1);
  localparam logic [GW-1:0] GAP_LAST  = GW'(GAP_CYC - 1);
  localparam logic [SW-1:0] STOP_LAST = SW'(STOP_CYC - 1);

  logic base_q, base_start;

  tbi_rate_gen u_rate (
    .clk        (clk),
    .rst        (rst),
    .run        (timer_run && cfg_done),
    .rate_div   (rate_div),
    .base_q     (base_q),
    .base_start (base_start)
  );

  // Write path state.
  tbi_pkg::tbi_wseq_t ws_q, ws_d;
  logic [7:0] wbyte_q, wbyte_d, crc_q, crc_d;
  logic [2:0] slot_q, slot_d;
  logic       loaded_q, loaded_d, stb_q, stb_d, amp_q, amp_d;

  always_comb begin
    ws_d = ws_q;
    wbyte_d = wbyte_q;
    crc_d = crc_q;
    slot_d = slot_q;
    loaded_d = loaded_q;
    wr_in_ready = 1'b0;
    if (base_start) begin
      loaded_d = 1'b0;
      unique case (ws_q)
        tbi_pkg::WS_IDLE: begin
          if (wr_in_valid) begin
            wr_in_ready = 1'b1;
            wbyte_d = wr_in;
            loaded_d = 1'b1;
            crc_d = tbi_pkg::tbi_crc_step(crc_q, wr_in);
          end else if (end_block) begin
            ws_d = tbi_pkg::WS_CRC_GAP;
            slot_d = 3'h1;
          end else if (file_mark_req) begin
            wbyte_d = tbi_pkg::FILE_MARK;
            loaded_d = 1'b1;
            ws_d = tbi_pkg::WS_LRC_GAP;
            slot_d = 3'h0;
          end
        end
        tbi_pkg::WS_CRC_GAP: begin
          if (slot_q == tbi_pkg::GAP_CHARS) begin
            wbyte_d = crc_q ^ tbi_pkg::CRC_FINAL;
            loaded_d = 1'b1;
            ws_d = tbi_pkg::WS_LRC_GAP;
            slot_d = 3'h0;
          end else begin
            slot_d = slot_q + 3'h1;
          end
        end
        tbi_pkg::WS_LRC_GAP: begin
          if (slot_q == tbi_pkg::GAP_CHARS) begin
            ws_d = tbi_pkg::WS_AMP;
          end else begin
            slot_d = slot_q + 3'h1;
          end
        end
        tbi_pkg::WS_AMP: begin
          ws_d = tbi_pkg::WS_IDLE;
        end
      endcase
    end
    if (crc_clear) begin
      crc_d = 8'h00;
    end
    // Strobes follow the byte by one cycle so the lines have settled.
    stb_d = cfg_done && base_q && loaded_q && wr_strobe_gate;
    amp_d = cfg_done && base_q && amp_clear_gate
            && ws_q == tbi_pkg::WS_AMP;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ws_q <= tbi_pkg::WS_IDLE;
      wbyte_q <= tbi_pkg::RESET_BYTE;
      crc_q <= 8'h00;
      slot_q <= 3'h0;
      loaded_q <= 1'b0;
      stb_q <= 1'b0;
      amp_q <= 1'b0;
    end else begin
      ws_q <= ws_d;
      wbyte_q <= wbyte_d;
      crc_q <= crc_d;
      slot_q <= slot_d;
      loaded_q <= loaded_d;
      stb_q <= stb_d;
      amp_q <= amp_d;
    end
  end

  assign wr_byte_lines = wbyte_q;
  assign wr_parity_line = tbi_pkg::tbi_odd_par(wbyte_q);
  assign wr_char_strobe = stb_q;
  assign wr_amp_clear_pulse = amp_q;
  assign cyclic_check_char = crc_q;
  assign seq_busy = ws_q != tbi_pkg::WS_IDLE;

  // Read path state.
  logic [7:0]    rbyte_q, rbyte_d;
  logic [GW-1:0] gap_q, gap_d;
  logic [SW-1:0] stop_q, stop_d;
  logic          rs_prev_q, rdy_q, rdy_d, perr_q, perr_d, clk9_q, clk9_d;
  logic          seen_q, seen_d, bend_q, bend_d, halt_q, halt_d, rise;
  logic [5:0]    cmd_q, cmd_d;

  always_comb begin
    rise = rd_char_strobe && !rs_prev_q;
    rbyte_d = rbyte_q;
    perr_d = perr_q;
    rdy_d = rdy_q;
    if (rd_ack) begin
      rdy_d = 1'b0;
    end
    if (rise) begin
      rbyte_d = rd_byte_lines;
      perr_d = ^{rd_byte_lines, rd_parity_line} == 1'b0;
      rdy_d = 1'b1;
    end
    clk9_d = |{rd_byte_lines, rd_parity_line};
    gap_d = gap_q;
    stop_d = stop_q;
    seen_d = seen_q;
    bend_d = bend_q;
    halt_d = halt_q;
    if (!rd_active) begin
      gap_d = '0;
      stop_d = '0;
      seen_d = 1'b0;
      bend_d = 1'b0;
      halt_d = 1'b0;
    end else if (rise && !bend_q) begin
      gap_d = '0;
      seen_d = 1'b1;
    end else if (seen_q && !bend_q) begin
      if (gap_q == GAP_LAST) begin
        bend_d = 1'b1;
      end else begin
        gap_d = gap_q + GW'(1);
      end
    end else if (bend_q && !halt_q) begin
      if (stop_q == STOP_LAST) begin
        halt_d = 1'b1;
      end else begin
        stop_d = stop_q + SW'(1);
      end
    end
    cmd_d = 6'h00;
    if (cfg_done) begin
      cmd_d = cmd_port;
      if (write_mode) begin
        cmd_d[tbi_pkg::CMD_FWD] = 1'b1;
        cmd_d[tbi_pkg::CMD_WSTAT] = 1'b1;
      end
      if (halt_q) begin
        cmd_d[tbi_pkg::CMD_FWD] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rs_prev_q <= 1'b0;
      rbyte_q <= 8'h00;
      rdy_q <= 1'b0;
      perr_q <= 1'b0;
      clk9_q <= 1'b0;
      gap_q <= '0;
      stop_q <= '0;
      seen_q <= 1'b0;
      bend_q <= 1'b0;
      halt_q <= 1'b0;
      cmd_q <= 6'h00;
    end else begin
      rs_prev_q <= rd_char_strobe;
      rbyte_q <= rbyte_d;
      rdy_q <= rdy_d;
      perr_q <= perr_d;
      clk9_q <= clk9_d;
      gap_q <= gap_d;
      stop_q <= stop_d;
      seen_q <= seen_d;
      bend_q <= bend_d;
      halt_q <= halt_d;
      cmd_q <= cmd_d;
    end
  end

  assign rd_byte = rbyte_q;
  assign rd_ready_flag_out = rdy_q;
  assign rd_block_end = bend_q;
  assign rd_char_clock = clk9_q;
  assign drive_cmd_bits = cmd_q;
  assign status_byte = {drive_status_bits, perr_q, rdy_q};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rd_edge;
    rd_char_strobe && !rs_prev_q;
  endsequence
  sequence s_crc_slot;
    base_start && ws_q == tbi_pkg::WS_CRC_GAP && slot_q == 3'h4;
  endsequence

  a_rd_capture: assert property (s_rd_edge |=> rd_byte == $past(rd_byte_lines)
    && rd_ready_flag_out)
    else $error("Read byte not captured on strobe.");
  a_rd_parity: assert property (s_rd_edge |=> status_byte[1] ==
    !(^{$past(rd_byte_lines), $past(rd_parity_line)}))
    else $error("Parity check result wrong.");
  a_ack_clears: assert property (rd_ack && !rise |=> !rd_ready_flag_out)
    else $error("Ready flag not cleared by read.");
  a_wr_odd: assert property (^{wr_byte_lines, wr_parity_line})
    else $error("Write character is not odd parity.");
  a_strobe_gated: assert property (wr_char_strobe |-> $past(wr_strobe_gate)
    && $past(base_q))
    else $error("Write strobe without gate.");
  a_cfg_quiet: assert property (!cfg_done |=> drive_cmd_bits == 6'h00
    && !wr_char_strobe && !wr_amp_clear_pulse)
    else $error("Drive outputs active before configuration.");
  a_write_cmds: assert property (cfg_done && write_mode && !halt_q
    |=> drive_cmd_bits[1:0] == 2'b11)
    else $error("Write mode commands missing.");
  a_crc_out: assert property (s_crc_slot |=> wr_byte_lines ==
    ($past(crc_q) ^ tbi_pkg::CRC_FINAL))
    else $error("Cyclic check not presented.");
  a_crc_update: assert property (wr_in_ready && !crc_clear |=>
    crc_q == tbi_pkg::tbi_crc_step($past(crc_q), $past(wr_in)))
    else $error("Cyclic check update wrong.");
endmodule : tbi_tape_if
`default_nettype wire

/* File: verification/tbi_drive_model.sv */
// Behavioural tape drive: read character source and write side recorder.
`timescale 1ns/10ps
`default_nettype none
module tbi_drive_model (
  // Clock
  input  wire logic       clk,
  // Read and status pins
  output logic [7:0]      rd_byte_lines,
  output logic            rd_parity_line,
  output logic            rd_char_strobe,
  output logic [5:0]      drive_status_bits,
  // Write pins
  input  wire logic [7:0] wr_byte_lines,
  input  wire logic       wr_parity_line,
  input  wire logic       wr_char_strobe,
  input  wire logic       wr_amp_clear_pulse
);
  // Characters per second at the recorded density and the slowest speed.
  localparam int DENSITY_CPI = 800;
  localparam int TENTH_IPS   = 125;
  localparam int CHAR_RATE   = DENSITY_CPI * TENTH_IPS / 10;
  int         cyc = 0;
  int         rise = 0;
  int         gap = 0;
  int         hi = 0;
  int         width = 0;
  int         cnt = 0;
  int         amp_cnt = 0;
  int         amp_gap = 0;
  logic [7:0] last_char = 8'h00;
  logic       par_ok = 1'h0;
  logic       s_q = 1'h0;
  logic       a_q = 1'h0;

  initial begin
    rd_byte_lines = 8'h00;
    rd_parity_line = 1'h1;
    rd_char_strobe = 1'h0;
    drive_status_bits = 6'h00;
  end

  task automatic set_status(input logic [5:0] v);
    drive_status_bits = v;
  endtask : set_status

  // Lines carry no hold after the strobe, so they flip to the inverse.
  task automatic send_char(input logic [7:0] b, input logic bad);
    @(posedge clk);
    #1;
    rd_byte_lines = b;
    rd_parity_line = (~^b) ^ bad;
    rd_char_strobe = 1'h1;
    repeat (2) @(posedge clk);
    #1;
    rd_char_strobe = 1'h0;
    rd_byte_lines = ~rd_byte_lines;
    rd_parity_line = ~rd_parity_line;
  endtask : send_char

  // Records each written character, strobe width and slot spacing.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    s_q <= wr_char_strobe;
    a_q <= wr_amp_clear_pulse;
    if (wr_char_strobe) hi <= hi + 1;
    if (wr_char_strobe && !s_q) begin
      cnt <= cnt + 1;
      gap <= cyc - rise;
      rise <= cyc;
      last_char <= wr_byte_lines;
      par_ok <= ^{wr_byte_lines, wr_parity_line};
    end
    if (!wr_char_strobe && s_q) begin
      width <= hi;
      hi <= 0;
    end
    // Each amplitude clear pulse is counted with its spacing from the last character strobe.
    if (wr_amp_clear_pulse && !a_q) begin
      amp_cnt <= amp_cnt + 1;
      amp_gap <= cyc - rise;
    end
  end
endmodule : tbi_drive_model
`default_nettype wire

/* File: verification/tb_tbi_tape_if.sv */
// Self-checking bench for the tape byte interface.
`timescale 1ns/10ps
`default_nettype none
module tb_tbi_tape_if;
  localparam int GAP = 20;
  localparam int STOP = 30;
  // Cycles between base pulses at a rate setting of three ticks.
  localparam int NOM = 3 * tbi_pkg::CLK_HZ / tbi_pkg::TICK_HZ;
  logic       clk = 1'h0;
  logic       rst = 1'h1;
  logic       cfg_done = 1'h0, timer_run = 1'h0, write_mode = 1'h0;
  logic       rd_active = 1'h0, wr_in_valid = 1'h0, rd_ack = 1'h0;
  logic       wr_strobe_gate = 1'h0, amp_clear_gate = 1'h0;
  logic       crc_clear = 1'h0, end_block = 1'h0, file_mark_req = 1'h0;
  logic [7:0] rate_div = 8'h00, wr_in = 8'h00, crc;
  logic [5:0] cmd_port = 6'h00, st;
  logic       wr_in_ready, seq_busy, rd_ready_flag_out, rd_block_end;
  logic       rd_char_clock, wr_parity_line, wr_char_strobe;
  logic       wr_amp_clear_pulse, rd_parity_line, rd_char_strobe;
  logic [7:0] cyclic_check_char, rd_byte, status_byte;
  logic [7:0] rd_byte_lines, wr_byte_lines;
  logic [5:0] drive_status_bits, drive_cmd_bits;
  logic [7:0] rb [4] = '{8'h00, 8'hA5, 8'hFF, 8'h10};
  logic [7:0] wb [4] = '{8'h00, 8'h81, 8'hFF, 8'h3C};
  logic [3:0] rbad = 4'h4;
  int         errors = 0;
  int         check_count = 0;
  int         n, per;

  tbi_tape_if #(.GAP_CYC(GAP), .STOP_CYC(STOP)) i_dut (
    .clk(clk), .rst(rst), .cfg_done(cfg_done), .timer_run(timer_run),
    .rate_div(rate_div), .cmd_port(cmd_port), .write_mode(write_mode),
    .rd_active(rd_active), .wr_in(wr_in), .wr_in_valid(wr_in_valid),
    .wr_in_ready(wr_in_ready), .wr_strobe_gate(wr_strobe_gate),
    .amp_clear_gate(amp_clear_gate), .crc_clear(crc_clear),
    .end_block(end_block), .file_mark_req(file_mark_req),
    .seq_busy(seq_busy), .cyclic_check_char(cyclic_check_char),
    .rd_byte(rd_byte), .rd_ack(rd_ack), .status_byte(status_byte),
    .rd_ready_flag_out(rd_ready_flag_out), .rd_block_end(rd_block_end),
    .rd_byte_lines(rd_byte_lines), .rd_parity_line(rd_parity_line),
    .rd_char_strobe(rd_char_strobe), .rd_char_clock(rd_char_clock),
    .drive_status_bits(drive_status_bits), .wr_byte_lines(wr_byte_lines),
    .wr_parity_line(wr_parity_line), .wr_char_strobe(wr_char_strobe),
    .wr_amp_clear_pulse(wr_amp_clear_pulse),
    .drive_cmd_bits(drive_cmd_bits));

  tbi_drive_model i_drv (
    .clk(clk), .rd_byte_lines(rd_byte_lines),
    .rd_parity_line(rd_parity_line), .rd_char_strobe(rd_char_strobe),
    .drive_status_bits(drive_status_bits), .wr_byte_lines(wr_byte_lines),
    .wr_parity_line(wr_parity_line), .wr_char_strobe(wr_char_strobe),
    .wr_amp_clear_pulse(wr_amp_clear_pulse));

  always #5 clk = ~clk;

  task automatic print_verdict();
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      check("wait bound", 0, 1);
      print_verdict();
    end
  endtask : bound

  // Holds the byte until the slot that takes it, then releases.
  task automatic put_byte(input logic [7:0] b);
    int k;
    wr_in = b;
    wr_in_valid = 1'h1;
    for (k = 0; k < 5000 && wr_in_ready !== 1'h1; k++) @(negedge clk);
    bound(k, 5000);
    tick(1);
    wr_in_valid = 1'h0;
  endtask : put_byte

  function automatic logic [7:0] crc_next(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    crc_next = {~^x, x[7:1]} ^ (x[0] ? tbi_pkg::CRC_POLY : 8'h00);
  endfunction : crc_next

  initial begin
    tick(10);
    rst = 1'h0;
    check("ready", rd_ready_flag_out, 0);
    check("flags", status_byte[1:0], 0);
    check("wpar", wr_parity_line, 1);
    check("char rate", i_drv.CHAR_RATE, tbi_pkg::CHAR_HZ);
    cmd_port = 6'h2A;
    write_mode = 1'h1;
    tick(3);
    check("cmd off", drive_cmd_bits, 0);
    check("strb", {wr_char_strobe, wr_amp_clear_pulse}, 0);
    cfg_done = 1'h1;
    tick(2);
    check("cmd wr", drive_cmd_bits, 6'h2B);
    write_mode = 1'h0;
    tick(2);
    check("cmd", drive_cmd_bits, 6'h2A);
    for (int i = 0; i < 4; i++) begin
      st = ~rb[i][5:0];
      i_drv.set_status(st);
      i_drv.send_char(rb[i], rbad[i]);
      tick(1);
      check("rd_byte", rd_byte, rb[i]);
      check("rd clk", rd_char_clock, 1);
      check("drv stat", status_byte[7:2], st);
      check("perr", status_byte[1], rbad[i]);
      check("rdy", status_byte[0], 1);
      rd_ack = 1'h1;
      tick(1);
      rd_ack = 1'h0;
      tick(1);
      check("ack", rd_ready_flag_out, 0);
    end
    cmd_port = 6'h01;
    rd_active = 1'h1;
    // An all-ones byte leaves every read line low once the strobe is gone.
    i_drv.send_char(8'hFF, 1'h0);
    for (n = 0; n < 200 && rd_block_end !== 1'h1; n++) tick(1);
    bound(n, 200);
    check("gap", n >= GAP - 3 && n <= GAP + 3, 1);
    for (n = 0; n < 200 && drive_cmd_bits[0] !== 1'h0; n++) tick(1);
    bound(n, 200);
    check("stop", n >= STOP - 3 && n <= STOP + 3, 1);
    check("idle clk", rd_char_clock, 0);
    rd_active = 1'h0;
    tick(3);
    check("rearm", {rd_block_end, drive_cmd_bits[0]}, 2'h1);
    rate_div = 8'h03;
    timer_run = 1'h1;
    put_byte(8'h5A);
    tick(2);
    check("wr byte", wr_byte_lines, 8'h5A);
    check("wr par", wr_parity_line, 1);
    tick(400);
    check("gated", i_drv.cnt, 0);
    crc_clear = 1'h1;
    tick(1);
    crc_clear = 1'h0;
    check("crc clr", cyclic_check_char, 0);
    crc = 8'h00;
    wr_strobe_gate = 1'h1;
    for (int i = 0; i < 4; i++) begin
      put_byte(wb[i]);
      crc = crc_next(crc, wb[i]);
      for (n = 0; n < 3000 && i_drv.cnt != i + 1; n++) tick(1);
      bound(n, 3000);
      check("wr char", i_drv.last_char, wb[i]);
      check("wr odd", i_drv.par_ok, 1);
    end
    per = i_drv.gap;
    check("per lo", per * 50 >= NOM * 49, 1);
    check("per hi", per * 50 <= NOM * 51, 1);
    check("width", i_drv.width, tbi_pkg::PULSE_CYC);
    check("crc run", cyclic_check_char, crc);
    end_block = 1'h1;
    for (n = 0; n < 3000 && seq_busy !== 1'h1; n++) tick(1);
    bound(n, 3000);
    end_block = 1'h0;
    amp_clear_gate = 1'h1;
    for (n = 0; n < 8000 && i_drv.cnt != 5; n++) tick(1);
    bound(n, 8000);
    check("cyclic_check_char", i_drv.last_char ^ crc, tbi_pkg::CRC_FINAL);
    check("cyclic_check_char odd", i_drv.par_ok, 1);
    check("crc gap", i_drv.gap, 5 * per);
    for (n = 0; n < 8000 && i_drv.amp_cnt != 1; n++) tick(1);
    bound(n, 8000);
    check("lrc gap", i_drv.amp_gap, 5 * per);
    for (n = 0; n < 3000 && seq_busy !== 1'h0; n++) tick(1);
    bound(n, 3000);
    amp_clear_gate = 1'h0;
    file_mark_req = 1'h1;
    for (n = 0; n < 3000 && seq_busy !== 1'h1; n++) tick(1);
    bound(n, 3000);
    file_mark_req = 1'h0;
    for (n = 0; n < 8000 && seq_busy !== 1'h0; n++) tick(1);
    bound(n, 8000);
    check("mark", i_drv.last_char, 8'h13);
    check("mark odd", i_drv.par_ok, 1);
    check("no crc", i_drv.cnt, 6);
    check("mark crc", cyclic_check_char, crc);
    check("amp gated", i_drv.amp_cnt, 1);
    print_verdict();
  end
endmodule : tb_tbi_tape_if
`default_nettype wire
